//--- hw/sdt_map.vh
// Register indices, field positions and reset values of the SCSI transfer block
`ifndef SDT_MAP_VH
`define SDT_MAP_VH

// ----------------------------------------------------------------------------
// Register select codes (read / write)
// ----------------------------------------------------------------------------
`define SDT_A_DATA      3'h0
`define SDT_A_ICMD      3'h1
`define SDT_A_MODE      3'h2
`define SDT_A_TCMD      3'h3
`define SDT_A_LINES     3'h4
`define SDT_A_STAT      3'h5
`define SDT_A_START_SND 3'h5
`define SDT_A_IDATA     3'h6
`define SDT_A_START_TRX 3'h6
`define SDT_A_CLEAR     3'h7
`define SDT_A_START_IRX 3'h7

// ----------------------------------------------------------------------------
// Mode control register fields
// ----------------------------------------------------------------------------
`define SDT_M_EN        1
`define SDT_M_EOTIE     3
`define SDT_M_PCHK      5
`define SDT_M_TGT       6
`define SDT_M_BLK       7

// ----------------------------------------------------------------------------
// Transfer status register fields
// ----------------------------------------------------------------------------
`define SDT_S_EOT       7
`define SDT_S_REQ       6
`define SDT_S_PERR      5
`define SDT_S_IRQ       4
`define SDT_S_PHASE     3
`define SDT_S_BERR      2
`define SDT_S_ATN       1
`define SDT_S_ACK       0

// ----------------------------------------------------------------------------
// Initiator and target command fields
// ----------------------------------------------------------------------------
`define SDT_I_DB        0
`define SDT_I_ATN       1
`define SDT_I_SEL       2
`define SDT_I_BSY       3
`define SDT_I_ACK       4
`define SDT_I_RST       7
`define SDT_T_IO        0
`define SDT_T_CD        1
`define SDT_T_MSG       2
`define SDT_T_REQ       3

// ----------------------------------------------------------------------------
// SCSI control line indices and widths
// ----------------------------------------------------------------------------
`define SDT_C_SEL       0
`define SDT_C_IO        1
`define SDT_C_CD        2
`define SDT_C_MSG       3
`define SDT_C_REQ       4
`define SDT_C_BSY       5
`define SDT_C_RST       6
`define SDT_C_ACK       7
`define SDT_C_ATN       8
`define SDT_CTL_W       9
`define SDT_SYNC_W      34
`define SDT_RST_BYTE    8'h00
`define SDT_RST_CTL     9'h000

`endif

//--- hw/sdt_sync.v
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sdt_sync #(
  parameter W       = 8,
  parameter RST_VAL = 0
) (
  // System
  input  wire         clk_i,
  input  wire         sys_rst_i,
  // Data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule

//--- hw/sdt_transfer.v
// SCSI bus controller transfer interface: PIO, pseudo-DMA, normal and block DMA
`timescale 1ns/1ps
`include "sdt_map.vh"

// Overview of operation
// - PIO read of live data location 000 checks SCSI parity.
// - With engine enabled, DMA receive bytes are parity checked as captured.
// - Enabled parity check and bad byte set parity fault, status bit 5.
// - Parity enable low masks parity interrupt and blocks the fault latch.
// - Read of clearing location clears parity fault latch.
// - End-of-process counts only with acknowledge plus read or write strobe.
// - Enabled engine plus valid end-of-process sets end latch, status bit 7.
// - End interrupt enable masks only the interrupt, not the latch.
// - Clearing engine enable clears the end-of-transfer latch.
// - In PIO, command register bits drive SCSI control lines directly.
// - Engine enable set and block bit clear gives interlocked DMA.
// - Writes to send, target receive or initiator receive start DMA.
// - Once started, engine runs SCSI and controller handshakes alone.
// - Request raised when a byte can move; controller reads or writes it.
// - DMA write byte captured when acknowledge-and-write cycle ends.
// - Block mode: controller waits on ready, no interlocked handshake needed.
// - Block send holds ready low while output byte not yet sent.
// - Block receive holds ready low while input data register empty.
// - Block mode accepts acknowledge held low for the whole transfer.
// - Block mode still raises request as in normal mode.
// - Clearing read clears interrupt latch and parity fault latch.
// - Receive captures data on REQ active as initiator, ACK as target.
// - End-of-process keeps enable; engine idles after last byte.
module sdt_transfer (
  // System
  input  wire                  clk_i,
  input  wire                  sys_rst_i,
  // CPU and DMA controller bus
  input  wire                  chip_select_n_i,
  input  wire                  io_read_strobe_n_i,
  input  wire                  io_write_strobe_n_i,
  input  wire [2:0]            register_select_lines_i,
  input  wire [7:0]            data_i,
  output wire [7:0]            data_o,
  output wire                  data_oe_o,
  input  wire                  transfer_acknowledge_n_i,
  input  wire                  end_of_process_input_n_i,
  output wire                  transfer_request_o,
  output wire                  ready_o,
  output wire                  irq_o,
  // SCSI bus, open drain, active low
  input  wire [`SDT_CTL_W-1:0] scsi_ctl_n_i,
  output wire [`SDT_CTL_W-1:0] scsi_ctl_n_o,
  output wire [`SDT_CTL_W-1:0] scsi_ctl_oe_o,
  input  wire [8:0]            scsi_db_n_i,
  output wire [8:0]            scsi_db_n_o,
  output wire                  scsi_db_oe_o
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ARM  = 4'h2;
  localparam [3:0] ST_STB  = 4'h4;
  localparam [3:0] ST_REL  = 4'h8;

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  wire [`SDT_SYNC_W-1:0] raw_w;
  wire [`SDT_SYNC_W-1:0] syn_w;

  assign raw_w = {chip_select_n_i, io_read_strobe_n_i, io_write_strobe_n_i,
                  transfer_acknowledge_n_i, end_of_process_input_n_i,
                  register_select_lines_i, data_i, scsi_ctl_n_i, scsi_db_n_i};

  sdt_sync #(
    .W       (`SDT_SYNC_W),
    .RST_VAL ({`SDT_SYNC_W{1'b1}})
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (raw_w),
    .q_o       (syn_w)
  );

  wire                  cs_s    = ~syn_w[33];
  wire                  rd_s    = ~syn_w[32];
  wire                  wr_s    = ~syn_w[31];
  wire                  ack_s   = ~syn_w[30];
  wire                  end_s   = ~syn_w[29];
  wire [2:0]            adr_s   = syn_w[28:26];
  wire [7:0]            dat_s   = syn_w[25:18];
  wire [`SDT_CTL_W-1:0] ctl_s   = ~syn_w[17:9];
  wire [8:0]            db_s    = ~syn_w[8:0];

  // --------------------------------------------------------------------------
  // Bus cycle decode
  // --------------------------------------------------------------------------
  reg        cpu_rd_q_reg;
  reg        cpu_wr_q_reg;
  reg        dma_rd_q_reg;
  reg        dma_wr_q_reg;
  reg [7:0]  wdat_reg;
  reg [2:0]  wadr_reg;

  wire cpu_rd     = cs_s & rd_s;
  wire cpu_wr     = cs_s & wr_s;
  wire dma_rd     = ack_s & rd_s;
  wire dma_wr     = ack_s & wr_s;
  wire cpu_rd_go  = cpu_rd & ~cpu_rd_q_reg;
  wire cpu_wr_end = ~cpu_wr & cpu_wr_q_reg;
  wire dma_rd_end = ~dma_rd & dma_rd_q_reg;
  wire dma_wr_end = ~dma_wr & dma_wr_q_reg;
  wire end_valid  = end_s & (dma_rd | dma_wr);
  wire clr_rd     = cpu_rd_go & (adr_s == `SDT_A_CLEAR);

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cpu_rd_q_reg <= 1'b0;
      cpu_wr_q_reg <= 1'b0;
      dma_rd_q_reg <= 1'b0;
      dma_wr_q_reg <= 1'b0;
      wdat_reg     <= `SDT_RST_BYTE;
      wadr_reg     <= `SDT_A_DATA;
    end else begin
      cpu_rd_q_reg <= cpu_rd;
      cpu_wr_q_reg <= cpu_wr;
      dma_rd_q_reg <= dma_rd;
      dma_wr_q_reg <= dma_wr;
      // Hold the last byte seen inside a write cycle; used when it ends
      if (cpu_wr | dma_wr) begin
        wdat_reg <= dat_s;
      end
      if (cpu_wr) begin
        wadr_reg <= adr_s;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  reg [7:0] icmd_reg;
  reg [7:0] mode_reg;
  reg [7:0] tcmd_reg;

  wire cpu_wr_done = cpu_wr_end;
  wire mode_wr     = cpu_wr_done & (wadr_reg == `SDT_A_MODE);
  wire eng_en      = mode_reg[`SDT_M_EN];
  wire tgt         = mode_reg[`SDT_M_TGT];
  wire blk         = mode_reg[`SDT_M_BLK];

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      icmd_reg <= `SDT_RST_BYTE;
      mode_reg <= `SDT_RST_BYTE;
      tcmd_reg <= `SDT_RST_BYTE;
    end else if (cpu_wr_done) begin
      case (wadr_reg)
        `SDT_A_ICMD: icmd_reg <= wdat_reg;
        `SDT_A_MODE: mode_reg <= wdat_reg;
        `SDT_A_TCMD: tcmd_reg <= wdat_reg;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Transfer engine
  // --------------------------------------------------------------------------
  reg [3:0] st_reg;
  reg       send_reg;
  reg       last_reg;
  reg       own_stb_reg;
  reg [7:0] odr_reg;
  reg       odr_full_reg;
  reg [7:0] idr_reg;
  reg       idr_full_reg;

  wire peer_act = tgt ? ctl_s[`SDT_C_ACK] : ctl_s[`SDT_C_REQ];
  wire busy     = ~st_reg[0];
  wire can_move = send_reg ? odr_full_reg : ~idr_full_reg;
  wire start_wr = cpu_wr_done & eng_en &
                  ((wadr_reg == `SDT_A_START_SND) | (wadr_reg == `SDT_A_START_TRX) |
                   (wadr_reg == `SDT_A_START_IRX));
  wire arm_go   = (st_reg == ST_ARM) & can_move & (tgt | peer_act);
  wire arm_stop = (st_reg == ST_ARM) & last_reg & ~(send_reg & odr_full_reg);
  // Capture point: REQ seen as initiator, ACK seen as target
  wire cap      = eng_en & ~send_reg & ~arm_stop &
                  ((arm_go & ~tgt) | ((st_reg == ST_STB) & tgt & peer_act));

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg       <= ST_IDLE;
      send_reg     <= 1'b0;
      last_reg     <= 1'b0;
      own_stb_reg  <= 1'b0;
      odr_reg      <= `SDT_RST_BYTE;
      odr_full_reg <= 1'b0;
      idr_reg      <= `SDT_RST_BYTE;
      idr_full_reg <= 1'b0;
    end else begin
      if (cpu_wr_done & (wadr_reg == `SDT_A_DATA)) begin
        odr_reg <= wdat_reg;
      end
      if (cap) begin
        idr_reg      <= db_s[7:0];
        idr_full_reg <= 1'b1;
      end else if (dma_rd_end) begin
        idr_full_reg <= 1'b0;
      end
      if (~eng_en) begin
        // Hard stop; a received byte stays readable
        st_reg       <= ST_IDLE;
        own_stb_reg  <= 1'b0;
        odr_full_reg <= 1'b0;
        last_reg     <= 1'b0;
      end else begin
        if (end_valid) begin
          last_reg <= 1'b1;
        end
        case (st_reg)
          ST_IDLE: ;
          ST_ARM: begin
            if (arm_stop) begin
              st_reg <= ST_IDLE;
            end else if (arm_go) begin
              own_stb_reg <= 1'b1;
              st_reg      <= ST_STB;
            end
          end
          ST_STB: begin
            if (tgt ? peer_act : ~peer_act) begin
              own_stb_reg <= 1'b0;
              st_reg      <= ST_REL;
            end
          end
          ST_REL: begin
            if (~peer_act) begin
              if (send_reg) begin
                odr_full_reg <= 1'b0;
              end
              st_reg <= ST_ARM;
            end
          end
          default: st_reg <= ST_IDLE;
        endcase
        if (dma_wr_end & busy & send_reg) begin
          odr_reg      <= wdat_reg;
          odr_full_reg <= 1'b1;
        end
        if (start_wr) begin
          st_reg       <= ST_ARM;
          send_reg     <= (wadr_reg == `SDT_A_START_SND);
          last_reg     <= 1'b0;
          own_stb_reg  <= 1'b0;
          odr_full_reg <= 1'b0;
          idr_full_reg <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Parity check, event latches and interrupt
  // --------------------------------------------------------------------------
  reg perr_reg;
  reg eot_reg;
  reg irq_reg;

  // Odd parity over eight data bits and the parity line
  wire par_bad = ~(^db_s);
  wire pio_chk = cpu_rd_go & (adr_s == `SDT_A_DATA);
  wire par_hit = mode_reg[`SDT_M_PCHK] & par_bad & (pio_chk | cap);
  wire eot_hit = eng_en & end_valid;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      perr_reg <= 1'b0;
      eot_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      // Clears first so that a coincident event still sets
      if (clr_rd) begin
        perr_reg <= 1'b0;
        irq_reg  <= 1'b0;
      end
      if (mode_wr & ~wdat_reg[`SDT_M_EN]) begin
        eot_reg <= 1'b0;
      end
      if (par_hit) begin
        perr_reg <= 1'b1;
      end
      if (eot_hit) begin
        eot_reg <= 1'b1;
      end
      if (par_hit | (eot_hit & mode_reg[`SDT_M_EOTIE])) begin
        irq_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status and read data
  // --------------------------------------------------------------------------
  reg [7:0] stat;
  reg [7:0] rd_mux;
  reg [7:0] data_reg;
  reg       data_oe_reg;
  reg       drq_reg;

  wire phase_ok = (tcmd_reg[`SDT_T_MSG] == ctl_s[`SDT_C_MSG]) &
                  (tcmd_reg[`SDT_T_CD] == ctl_s[`SDT_C_CD]) &
                  (tcmd_reg[`SDT_T_IO] == ctl_s[`SDT_C_IO]);

  always @* begin
    stat                = 8'h00;
    stat[`SDT_S_EOT]    = eot_reg;
    stat[`SDT_S_REQ]    = drq_reg;
    stat[`SDT_S_PERR]   = perr_reg;
    stat[`SDT_S_IRQ]    = irq_reg;
    stat[`SDT_S_PHASE]  = phase_ok;
    stat[`SDT_S_ATN]    = ctl_s[`SDT_C_ATN];
    stat[`SDT_S_ACK]    = ctl_s[`SDT_C_ACK];
    case (adr_s)
      `SDT_A_DATA:  rd_mux = db_s[7:0];
      `SDT_A_ICMD:  rd_mux = icmd_reg;
      `SDT_A_MODE:  rd_mux = mode_reg;
      `SDT_A_TCMD:  rd_mux = tcmd_reg;
      `SDT_A_LINES: rd_mux = {ctl_s[`SDT_C_RST], ctl_s[`SDT_C_BSY], ctl_s[`SDT_C_REQ],
                              ctl_s[`SDT_C_MSG], ctl_s[`SDT_C_CD], ctl_s[`SDT_C_IO],
                              ctl_s[`SDT_C_SEL], db_s[8]};
      `SDT_A_STAT:  rd_mux = stat;
      `SDT_A_IDATA: rd_mux = idr_reg;
      default:      rd_mux = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  reg                  ready_reg;
  reg [8:0]            db_out_reg;
  reg                  db_oe_reg;
  reg [`SDT_CTL_W-1:0] ctl_oe_reg;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drq_reg     <= 1'b0;
      ready_reg   <= 1'b1;
      data_reg    <= `SDT_RST_BYTE;
      data_oe_reg <= 1'b0;
      db_out_reg  <= 9'h1FF;
      db_oe_reg   <= 1'b0;
      ctl_oe_reg  <= `SDT_RST_CTL;
    end else begin
      drq_reg     <= eng_en & busy & ~last_reg &
                     (send_reg ? ~odr_full_reg : idr_full_reg);
      ready_reg   <= ~(eng_en & blk & busy &
                       (send_reg ? odr_full_reg : ~idr_full_reg));
      // Read strobe with acknowledge, even held, presents the input byte
      data_reg    <= dma_rd ? idr_reg : rd_mux;
      data_oe_reg <= cpu_rd | dma_rd;
      db_out_reg  <= ~{~(^odr_reg), odr_reg};
      db_oe_reg   <= icmd_reg[`SDT_I_DB] | (eng_en & busy & send_reg);
      ctl_oe_reg[`SDT_C_SEL] <= icmd_reg[`SDT_I_SEL];
      ctl_oe_reg[`SDT_C_BSY] <= icmd_reg[`SDT_I_BSY];
      ctl_oe_reg[`SDT_C_RST] <= icmd_reg[`SDT_I_RST];
      ctl_oe_reg[`SDT_C_ATN] <= icmd_reg[`SDT_I_ATN];
      ctl_oe_reg[`SDT_C_ACK] <= icmd_reg[`SDT_I_ACK] | (own_stb_reg & ~tgt);
      ctl_oe_reg[`SDT_C_REQ] <= tcmd_reg[`SDT_T_REQ] | (own_stb_reg & tgt);
      ctl_oe_reg[`SDT_C_MSG] <= tcmd_reg[`SDT_T_MSG];
      ctl_oe_reg[`SDT_C_CD]  <= tcmd_reg[`SDT_T_CD];
      ctl_oe_reg[`SDT_C_IO]  <= tcmd_reg[`SDT_T_IO];
    end
  end

  assign transfer_request_o = drq_reg;
  assign ready_o            = ready_reg;
  assign irq_o              = irq_reg;
  assign data_o             = data_reg;
  assign data_oe_o          = data_oe_reg;
  assign scsi_db_n_o        = db_out_reg;
  assign scsi_db_oe_o       = db_oe_reg;
  assign scsi_ctl_n_o       = `SDT_RST_CTL;
  assign scsi_ctl_oe_o      = ctl_oe_reg;
endmodule

//--- verification/sdt_scsi_peer.sv
// SCSI target peer model that answers the block's REQ/ACK handshake
`timescale 1ns/1ps
module sdt_scsi_peer (
  // Control
  input  wire       clk_i,
  input  wire       go_i,
  input  wire       tx_i,
  input  wire [7:0] byte_i,
  // SCSI wire, active low
  input  wire       ack_n_i,
  input  wire [8:0] db_n_i,
  output reg        req_n_o,
  output reg        io_n_o,
  output reg  [8:0] db_n_o,
  output reg  [7:0] got_o
);
  integer k;
  initial begin
    req_n_o = 1'b1;
    io_n_o  = 1'b1;
    db_n_o  = 9'h0FF;
    got_o   = 8'h00;
    forever begin
      @(posedge go_i);
      @(posedge clk_i);
      #1;
      io_n_o = ~tx_i;
      if (tx_i)
        db_n_o = ~{~^byte_i, byte_i};
      repeat (3) @(posedge clk_i);
      #1;
      req_n_o = 1'b0;
      k = 0;
      while (ack_n_i && k < 100) begin
        @(posedge clk_i);
        k = k + 1;
      end
      got_o = ~db_n_i[7:0];
      #1;
      req_n_o = 1'b1;
      while (!ack_n_i && k < 200) begin
        @(posedge clk_i);
        k = k + 1;
      end
      #1;
      // Released data lines show the inverse of the last byte
      db_n_o = ~db_n_o;
    end
  end
endmodule

//--- verification/sdt_transfer_properties.sv
// Port-level checker for the SCSI transfer block
`timescale 1ns/1ps
module sdt_transfer_chk (
  // System
  input wire       clk_i,
  input wire       sys_rst_i,
  // Bus side
  input wire       chip_select_n_i,
  input wire       io_read_strobe_n_i,
  input wire       io_write_strobe_n_i,
  input wire [2:0] register_select_lines_i,
  input wire       transfer_acknowledge_n_i,
  input wire       transfer_request_o,
  input wire       data_oe_o,
  input wire       irq_o,
  // SCSI side, plus ready
  input wire [8:0] scsi_ctl_n_i,
  input wire       ready_o,
  input wire [8:0] scsi_db_n_o,
  input wire       scsi_db_oe_o
);
  reg  [3:0] cs_idle;
  reg  [3:0] quiet;
  wire       calm = chip_select_n_i & transfer_acknowledge_n_i & scsi_ctl_n_i[4] & scsi_ctl_n_i[7];
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cs_idle <= 4'h0;
      quiet   <= 4'h0;
    end else begin
      cs_idle <= !chip_select_n_i ? 4'h0 : cs_idle + {3'h0, cs_idle != 4'hF};
      quiet   <= !calm ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    end
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_req_ready: assert property (!(transfer_request_o && !ready_o))
    else $error("request raised while ready held low");
  a_irq_hold: assert property (irq_o && cs_idle >= 4'h6 |=> irq_o)
    else $error("interrupt dropped without clearing read");
  a_irq_clear: assert property ((!chip_select_n_i && !io_read_strobe_n_i &&
    register_select_lines_i == 3'h7 && transfer_acknowledge_n_i)[*7] |-> !irq_o)
    else $error("clearing read left interrupt set");
  a_irq_cause: assert property ($rose(irq_o) |-> quiet < 4'h8)
    else $error("interrupt raised with no bus or SCSI activity");
  a_read_drive: assert property ($rose(data_oe_o) |-> !$past(io_read_strobe_n_i, 3))
    else $error("data driven without read strobe");
  a_read_release: assert property (io_read_strobe_n_i[*5] |-> !data_oe_o)
    else $error("data still driven after read ended");
  a_req_drop: assert property (transfer_request_o && $rose(io_write_strobe_n_i) &&
    !$past(transfer_acknowledge_n_i) |-> ##[1:6] !transfer_request_o)
    else $error("request kept after byte written");
  a_out_parity: assert property (scsi_db_oe_o |-> ^(~scsi_db_n_o))
    else $error("driven SCSI byte has even parity");
  c_irq: cover property ($rose(irq_o));
  c_req: cover property ($fell(transfer_request_o));
  c_drive: cover property ($rose(scsi_db_oe_o));
  c_wait: cover property ($fell(ready_o));
endmodule

bind sdt_transfer sdt_transfer_chk u_chk (.*);

//--- verification/sdt_transfer_tb_top.sv
// Self-checking bench for the SCSI transfer block
`timescale 1ns/1ps
`include "sdt_map.vh"
`define CHK(n, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
  fail_count = fail_count + 1; $display("BAD %s exp %h got %h", n, e, g); end end
module sdt_transfer_tb_top;
  reg        clk_i = 1'b0;
  reg        sys_rst_i = 1'b1;
  reg        cs_n = 1'b1;
  reg        rd_n = 1'b1;
  reg        wr_n = 1'b1;
  reg        ack_n = 1'b1;
  reg        eop_n = 1'b1;
  reg        go = 1'b0;
  reg        tx = 1'b0;
  reg        bad = 1'b0;
  reg  [2:0] sel = 3'h0;
  reg  [7:0] din = 8'h00;
  reg  [7:0] txb = 8'h00;
  reg  [7:0] q;
  integer    fail_count = 0;
  integer    n_tests = 0;
  integer    p;
  integer    i;
  wire [7:0] dout;
  wire [7:0] got;
  wire       doe, trq, rdy, irq, req_n, io_n, db_oe;
  wire [8:0] ctl_o, ctl_oe, db_o, pdb;
  wire [8:0] ctl_w = {4'hF, req_n, 2'h3, io_n, 1'b1} & ~(ctl_oe & ~ctl_o);
  wire [8:0] dbw = (db_oe ? db_o : pdb) ^ {bad, 8'h00};

  always #4 clk_i = ~clk_i;

  sdt_transfer DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .chip_select_n_i(cs_n),
    .io_read_strobe_n_i(rd_n), .io_write_strobe_n_i(wr_n), .register_select_lines_i(sel),
    .data_i(din), .data_o(dout), .data_oe_o(doe), .transfer_acknowledge_n_i(ack_n),
    .end_of_process_input_n_i(eop_n), .transfer_request_o(trq), .ready_o(rdy), .irq_o(irq),
    .scsi_ctl_n_i(ctl_w), .scsi_ctl_n_o(ctl_o), .scsi_ctl_oe_o(ctl_oe), .scsi_db_n_i(dbw),
    .scsi_db_n_o(db_o), .scsi_db_oe_o(db_oe));
  sdt_scsi_peer u_peer (.clk_i(clk_i), .go_i(go), .tx_i(tx), .byte_i(txb),
    .ack_n_i(ctl_w[`SDT_C_ACK]), .db_n_i(dbw), .req_n_o(req_n), .io_n_o(io_n),
    .db_n_o(pdb), .got_o(got));

  // ----
  // Bus cycle: CPU (dma=0) or DMA controller (dma=1), read or write
  // ----
  task cyc(input [2:0] a, input [7:0] d, input w, input dma, input e);
    begin
      @(posedge clk_i);
      #1;
      sel = a;
      din = d;
      cs_n = dma;
      ack_n = ~dma;
      eop_n = ~e;
      wr_n = ~w;
      rd_n = w;
      repeat (8) @(posedge clk_i);
      while (dma && rdy !== 1'b1) begin
        @(posedge clk_i);
      end
      q = dout;
      #1;
      {cs_n, ack_n, eop_n, wr_n, rd_n} = 5'h1F;
      repeat (4) @(posedge clk_i);
      #1;
    end
  endtask

  task wait_trq;
    begin
      i = 0;
      while (trq !== 1'b1 && i < 300) begin
        @(posedge clk_i);
        i = i + 1;
      end
      #1;
    end
  endtask

  task test_done;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  initial begin
    #40000;
    fail_count = fail_count + 1;
    test_done;
  end

  initial begin
    repeat (6) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    cyc(`SDT_A_STAT, 8'h00, 0, 0, 0);
    `CHK("stat_rst", 8'h00, q & 8'hB4)
    cyc(`SDT_A_ICMD, 8'h02, 1, 0, 0);
    `CHK("atn_oe", 1'b1, ctl_oe[`SDT_C_ATN])
    cyc(`SDT_A_STAT, 8'h00, 0, 0, 0);
    `CHK("atn_st", 1'b1, q[`SDT_S_ATN])
    cyc(`SDT_A_ICMD, 8'h00, 1, 0, 0);
    for (p = 0; p < 2; p = p + 1) begin
      cyc(`SDT_A_MODE, p ? 8'h20 : 8'h00, 1, 0, 0);
      bad = 1'b1;
      cyc(`SDT_A_DATA, 8'h00, 0, 0, 0);
      bad = 1'b0;
      cyc(`SDT_A_STAT, 8'h00, 0, 0, 0);
      `CHK("perr", {p[0], p[0]}, q[5:4])
      `CHK("perr_irq", p[0], irq)
      cyc(`SDT_A_CLEAR, 8'h00, 0, 0, 0);
      cyc(`SDT_A_STAT, 8'h00, 0, 0, 0);
      `CHK("perr_clr", 2'h0, q[5:4] | {irq, irq})
    end
    cyc(`SDT_A_MODE, 8'h02, 1, 0, 0);
    eop_n = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    eop_n = 1'b1;
    cyc(`SDT_A_IDATA, 8'h00, 0, 0, 1);
    cyc(`SDT_A_STAT, 8'h00, 0, 0, 0);
    `CHK("eot_none", 1'b0, q[`SDT_S_EOT])
    cyc(`SDT_A_DATA, 8'h00, 0, 1, 1);
    cyc(`SDT_A_STAT, 8'h00, 0, 0, 0);
    `CHK("eot_set", 1'b1, q[`SDT_S_EOT])
    `CHK("eot_mask", 1'b0, irq)
    cyc(`SDT_A_MODE, 8'h00, 0, 0, 0);
    `CHK("en_kept", 8'h02, q)
    cyc(`SDT_A_MODE, 8'h00, 1, 0, 0);
    cyc(`SDT_A_STAT, 8'h00, 0, 0, 0);
    `CHK("eot_clr", 1'b0, q[`SDT_S_EOT])
    cyc(`SDT_A_MODE, 8'h0A, 1, 0, 0);
    cyc(`SDT_A_DATA, 8'h00, 0, 1, 1);
    `CHK("eot_irq", 1'b1, irq)
    cyc(`SDT_A_CLEAR, 8'h00, 0, 0, 0);
    `CHK("irq_clr", 1'b0, irq)
    cyc(`SDT_A_TCMD, 8'h01, 1, 0, 0);
    cyc(`SDT_A_MODE, 8'h02, 1, 0, 0);
    cyc(`SDT_A_START_IRX, 8'h00, 1, 0, 0);
    tx = 1'b1;
    txb = 8'hA5;
    go = 1'b1;
    wait_trq;
    go = 1'b0;
    `CHK("rx_req", 1'b1, trq)
    cyc(`SDT_A_DATA, 8'h00, 0, 1, 0);
    `CHK("rx_byte", 8'hA5, q)
    cyc(`SDT_A_TCMD, 8'h00, 1, 0, 0);
    cyc(`SDT_A_START_SND, 8'h00, 1, 0, 0);
    wait_trq;
    `CHK("tx_req", 1'b1, trq)
    cyc(`SDT_A_DATA, 8'h5A, 1, 1, 0);
    tx = 1'b0;
    go = 1'b1;
    i = 0;
    while (got !== 8'h5A && i < 200) begin
      @(posedge clk_i);
      i = i + 1;
    end
    #1;
    `CHK("tx_byte", 8'h5A, got)
    go = 1'b0;
    cyc(`SDT_A_MODE, 8'h82, 1, 0, 0);
    cyc(`SDT_A_START_IRX, 8'h00, 1, 0, 0);
    `CHK("blk_rx_wait", 1'b0, rdy)
    txb = 8'h3C;
    tx = 1'b1;
    go = 1'b1;
    cyc(`SDT_A_DATA, 8'h00, 0, 1, 0);
    go = 1'b0;
    `CHK("blk_rx_byte", 8'h3C, q)
    cyc(`SDT_A_START_SND, 8'h00, 1, 0, 0);
    cyc(`SDT_A_DATA, 8'hC3, 1, 1, 0);
    `CHK("blk_tx_wait", 1'b0, rdy)
    tx = 1'b0;
    go = 1'b1;
    repeat (30) @(posedge clk_i);
    #1;
    `CHK("blk_tx_byte", 8'hC3, got)
    `CHK("blk_tx_rdy", 1'b1, rdy)
    test_done;
  end
endmodule
